// [nand_host_cfg.svh]
// Timing, opcode and count constants for the NAND host sequencer
`ifndef NAND_HOST_CFG_SVH
`define NAND_HOST_CFG_SVH

`define NH_CLK_PS 10000
`define NH_T_PHASE_NS 25
`define NH_PHASE_CYC ((`NH_T_PHASE_NS * 1000 + `NH_CLK_PS - 1) / `NH_CLK_PS)
`define NH_T_WB_NS 100
`define NH_WB_CYC ((`NH_T_WB_NS * 1000 + `NH_CLK_PS - 1) / `NH_CLK_PS)
`define NH_T_WHR_NS 60
`define NH_WHR_CYC ((`NH_T_WHR_NS * 1000 + `NH_CLK_PS - 1) / `NH_CLK_PS)

`define NH_OPC_RESET 8'hff
`define NH_OPC_STATUS 8'h70
`define NH_OPC_ID 8'h90
`define NH_OPC_UID 8'hed
`define NH_OPC_READ 8'h00
`define NH_OPC_MOVE_RD 8'h35
`define NH_OPC_MOVE_WR 8'h85
`define NH_OPC_REPROG 8'h8b
`define NH_OPC_PROG 8'h80
`define NH_OPC_CONFIRM 8'h10
`define NH_OPC_CACHE 8'h15
`define NH_OPC_ERASE 8'h60
`define NH_OPC_ERASE_GO 8'hd0

`define NH_ID_BYTES 16'h0004
`define NH_UID_BYTES 16'h0020
`define NH_UID_HALF 16'h0010
`define NH_UID_ONES 8'hff

`endif

// [nand_host_pkg.sv]
// Types shared by the NAND host sequencer
package nand_host_pkg;

    typedef enum logic [2:0] {
        OP_RESET, OP_ID, OP_UID, OP_MOVE_RD, OP_MOVE_WR, OP_REPROG,
        OP_ERASE, OP_PROG
    } op_t;

    typedef enum logic [2:0] {
        S_IDLE, S_CMD1, S_ADDR, S_WDATA, S_CMD2, S_WAIT, S_RDY, S_RDATA
    } st_t;

    typedef struct packed {
        op_t op;
        logic cache;
        logic [39:0] addr;
        logic [15:0] len;
    } req_t;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
        logic [7:0] io_out;
        logic io_oe;
    } pins_t;

endpackage

// [nand_host.sv]
// Host sequencer driving a NAND device over its multiplexed pins
`timescale 1ns/1ps
`include "nand_host_cfg.svh"
// Overview of operation
// - Bytes past the fourth ID byte are undefined; not relied on.
// - Host XORs value with complement; anything but all ones is bad.
// - Host waits for ready before reading unique-identifier bytes.
// - Copy uses 00, four addresses, 35; then 85, four addresses, data, 10.
// - Re-program uses 8B, five addresses, data, 10; never while busy.
// - Command latched on write-enable rise with CE low, CLE high, ALE low.
// - Address latched on write-enable rise with CE low, ALE high, CLE low.
module nand_host (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_start,
    input wire nand_host_pkg::req_t req,
    input wire logic wp_enable,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic rb_n,
    input wire logic [7:0] io_in,
    output nand_host_pkg::pins_t pins_q,
    output logic wr_ready_q,
    output logic rd_valid_q,
    output logic [7:0] rd_data_q,
    output logic busy_q,
    output logic done_q,
    output logic refused_q,
    output logic aborted_q,
    output logic uid_bad_q
);
    import nand_host_pkg::*;

    localparam int PH_CYC = `NH_PHASE_CYC;

    // ------------------------------------------------------------
    // Opcode tables
    // ------------------------------------------------------------
    function automatic logic [7:0] cmd1_of(input op_t o);
        case (o)
            OP_RESET: cmd1_of = `NH_OPC_RESET;
            OP_ID: cmd1_of = `NH_OPC_ID;
            OP_UID: cmd1_of = `NH_OPC_UID;
            OP_MOVE_RD: cmd1_of = `NH_OPC_READ;
            OP_MOVE_WR: cmd1_of = `NH_OPC_MOVE_WR;
            OP_REPROG: cmd1_of = `NH_OPC_REPROG;
            OP_ERASE: cmd1_of = `NH_OPC_ERASE;
            default: cmd1_of = `NH_OPC_PROG;
        endcase
    endfunction

    function automatic logic [2:0] naddr_of(input op_t o);
        case (o)
            OP_RESET: naddr_of = 3'h0;
            OP_ID, OP_UID: naddr_of = 3'h1;
            OP_REPROG: naddr_of = 3'h5;
            OP_ERASE: naddr_of = 3'h2;
            default: naddr_of = 3'h4;
        endcase
    endfunction

    function automatic logic is_modify(input op_t o);
        is_modify = (o == OP_MOVE_WR) || (o == OP_REPROG) ||
            (o == OP_ERASE) || (o == OP_PROG);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and phase divider
    // ------------------------------------------------------------
    logic rb_m_q, rb_s_q;
    logic [7:0] io_m_q, io_s_q;
    logic [7:0] div_q;
    logic tick;

    always_ff @(posedge core_clk) begin
        rb_m_q <= rb_n;
        rb_s_q <= rb_m_q;
        io_m_q <= io_in;
        io_s_q <= io_m_q;
    end

    assign tick = (div_q == 8'(PH_CYC - 1));

    always_ff @(posedge core_clk) begin
        if (sys_rst || tick) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    st_t state_q;
    op_t op_q;
    logic cache_q;
    logic [39:0] addr_q;
    logic [15:0] len_q, cnt_q, wait_q;
    logic [2:0] acnt_q;
    logic [1:0] ph_q;
    logic [7:0] uid_q [16];
    logic rst_run, take, abort_ok;

    assign rst_run = (op_q == OP_RESET) && (state_q != S_IDLE);
    // Reset may cut our own busy wait, but never a running reset
    assign abort_ok = req_start && (req.op == OP_RESET) && !rst_run &&
        (state_q == S_RDY);
    // Only reset while the device is busy; modify needs write enable
    assign take = req_start && (state_q == S_IDLE) &&
        (rb_s_q || req.op == OP_RESET) &&
        !(is_modify(req.op) && !wp_enable);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            op_q <= OP_RESET;
            cache_q <= 1'b0;
            addr_q <= 40'h0;
            len_q <= 16'h0;
            cnt_q <= 16'h0;
            wait_q <= 16'h0;
            acnt_q <= 3'h0;
            ph_q <= 2'h0;
            pins_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                read_strobe_n: 1'b1, wp_n: 1'b0, io_out: 8'h00,
                io_oe: 1'b0};
            wr_ready_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_data_q <= 8'h00;
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            rd_valid_q <= 1'b0;
            refused_q <= req_start && !take && !abort_ok;
            case (state_q)
                S_IDLE: begin
                    // Write protect moves only in standby
                    pins_q.wp_n <= wp_enable;
                    pins_q.ce_n <= 1'b1;
                    pins_q.io_oe <= 1'b0;
                    if (take) begin
                        op_q <= req.op;
                        cache_q <= req.cache;
                        addr_q <= req.addr;
                        len_q <= req.len;
                        state_q <= S_CMD1;
                        ph_q <= 2'h0;
                        pins_q.ce_n <= 1'b0;
                        pins_q.cle <= 1'b1;
                        pins_q.we_n <= 1'b0;
                        pins_q.io_out <= cmd1_of(req.op);
                        pins_q.io_oe <= 1'b1;
                    end
                end
                S_CMD1, S_ADDR, S_CMD2: if (tick) begin
                    if (ph_q == 2'h0) begin
                        pins_q.we_n <= 1'b1;
                        ph_q <= 2'h1;
                    end else begin
                        ph_q <= 2'h0;
                        pins_q.cle <= 1'b0;
                        pins_q.ale <= 1'b0;
                        if (state_q == S_ADDR) begin
                            addr_q <= {8'h00, addr_q[39:8]};
                            acnt_q <= acnt_q + 3'h1;
                        end else begin
                            acnt_q <= 3'h0;
                        end
                        if ((state_q == S_CMD1 && naddr_of(op_q) != 3'h0) ||
                            (state_q == S_ADDR &&
                             acnt_q + 3'h1 != naddr_of(op_q))) begin
                            state_q <= S_ADDR;
                            pins_q.ale <= 1'b1;
                            pins_q.we_n <= 1'b0;
                            pins_q.io_out <= (state_q == S_ADDR) ?
                                addr_q[15:8] : addr_q[7:0];
                        end else if (state_q == S_ADDR &&
                            (op_q == OP_ID || op_q == OP_UID)) begin
                            state_q <= S_WAIT;
                            cnt_q <= 16'h0;
                            pins_q.io_oe <= 1'b0;
                            wait_q <= (op_q == OP_ID) ? 16'(`NH_WHR_CYC) :
                                16'(`NH_WB_CYC);
                        end else if (state_q == S_ADDR && len_q != 16'h0 &&
                            op_q != OP_MOVE_RD && op_q != OP_ERASE) begin
                            state_q <= S_WDATA;
                            cnt_q <= 16'h0;
                            wr_ready_q <= 1'b1;
                        end else if (state_q == S_ADDR) begin
                            state_q <= S_CMD2;
                            pins_q.cle <= 1'b1;
                            pins_q.we_n <= 1'b0;
                            pins_q.io_out <= (op_q == OP_MOVE_RD) ?
                                `NH_OPC_MOVE_RD : (op_q == OP_ERASE) ?
                                `NH_OPC_ERASE_GO : (op_q == OP_PROG &&
                                cache_q) ? `NH_OPC_CACHE :
                                `NH_OPC_CONFIRM;
                        end else begin
                            state_q <= S_WAIT;
                            pins_q.io_oe <= 1'b0;
                            wait_q <= 16'(`NH_WB_CYC);
                        end
                    end
                end
                S_WDATA: begin
                    if (ph_q == 2'h0 && wr_valid && wr_ready_q) begin
                        wr_ready_q <= 1'b0;
                        pins_q.io_out <= wr_data;
                        pins_q.we_n <= 1'b0;
                        ph_q <= 2'h1;
                    end else if (tick && ph_q == 2'h1) begin
                        pins_q.we_n <= 1'b1;
                        ph_q <= 2'h2;
                    end else if (tick && ph_q == 2'h2) begin
                        ph_q <= 2'h0;
                        cnt_q <= cnt_q + 16'h1;
                        if (cnt_q + 16'h1 == len_q) begin
                            state_q <= S_CMD2;
                            pins_q.cle <= 1'b1;
                            pins_q.we_n <= 1'b0;
                            pins_q.io_out <= (op_q == OP_PROG && cache_q) ?
                                `NH_OPC_CACHE : `NH_OPC_CONFIRM;
                        end else begin
                            wr_ready_q <= 1'b1;
                        end
                    end
                end
                S_WAIT: begin
                    if (wait_q != 16'h0) begin
                        wait_q <= wait_q - 16'h1;
                    end else if (op_q == OP_ID) begin
                        state_q <= S_RDATA;
                        ph_q <= 2'h0;
                    end else begin
                        state_q <= S_RDY;
                    end
                end
                S_RDY: begin
                    if (abort_ok) begin
                        op_q <= OP_RESET;
                        state_q <= S_CMD1;
                        ph_q <= 2'h0;
                        pins_q.cle <= 1'b1;
                        pins_q.we_n <= 1'b0;
                        pins_q.io_out <= `NH_OPC_RESET;
                        pins_q.io_oe <= 1'b1;
                    end else if (rb_s_q && op_q == OP_UID) begin
                        state_q <= S_RDATA;
                        ph_q <= 2'h0;
                    end else if (rb_s_q) begin
                        state_q <= S_IDLE;
                        done_q <= 1'b1;
                    end
                end
                S_RDATA: if (tick) begin
                    if (ph_q == 2'h0) begin
                        pins_q.read_strobe_n <= 1'b0;
                        ph_q <= 2'h1;
                    end else if (ph_q == 2'h1) begin
                        ph_q <= 2'h2;
                    end else begin
                        pins_q.read_strobe_n <= 1'b1;
                        ph_q <= 2'h0;
                        rd_valid_q <= 1'b1;
                        rd_data_q <= io_s_q;
                        cnt_q <= cnt_q + 16'h1;
                        // ID stops after its four defined bytes; unique identifier after 32
                        if (cnt_q + 16'h1 == ((op_q == OP_ID) ?
                            `NH_ID_BYTES : `NH_UID_BYTES)) begin
                            state_q <= S_IDLE;
                            done_q <= 1'b1;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status flags and unique-identifier check
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            aborted_q <= 1'b0;
        end else begin
            busy_q <= (state_q != S_IDLE) || take;
            if (abort_ok) begin
                aborted_q <= is_modify(op_q);
            end else if (take) begin
                aborted_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            uid_bad_q <= 1'b0;
        end else if (take) begin
            uid_bad_q <= 1'b0;
        end else if (state_q == S_RDATA && op_q == OP_UID && tick &&
            ph_q == 2'h2 && cnt_q >= `NH_UID_HALF) begin
            if ((uid_q[cnt_q[3:0]] ^ io_s_q) != `NH_UID_ONES) begin
                uid_bad_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (state_q == S_RDATA && tick && ph_q == 2'h2 &&
            cnt_q < `NH_UID_HALF) begin
            uid_q[cnt_q[3:0]] <= io_s_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] aseen_q;
    always_ff @(posedge core_clk) begin
        if (sys_rst || (pins_q.cle && $rose(pins_q.we_n))) begin
            aseen_q <= 3'h0;
        end else if (pins_q.ale && $rose(pins_q.we_n)) begin
            aseen_q <= aseen_q + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_cmd_latch_pins: assert property (
        $rose(pins_q.we_n) && pins_q.cle
        |-> !pins_q.ale && !pins_q.ce_n && pins_q.read_strobe_n)
        else $error("command latched with wrong control pins");
    a_addr_latch_pins: assert property (
        $rose(pins_q.we_n) && pins_q.ale
        |-> !pins_q.cle && !pins_q.ce_n && pins_q.read_strobe_n)
        else $error("address latched with wrong control pins");
    a_busy_cmd_only: assert property (
        $fell(pins_q.we_n) && pins_q.cle && $past(state_q) == S_RDY
        |-> pins_q.io_out == `NH_OPC_RESET)
        else $error("non-reset command while device busy");
    a_reset_no_repeat: assert property (
        $fell(pins_q.we_n) && pins_q.cle && pins_q.io_out == `NH_OPC_RESET
        |-> !($past(op_q) == OP_RESET && $past(state_q) != S_IDLE))
        else $error("second reset during running reset");
    a_wp_modify: assert property (
        $rose(pins_q.we_n) && pins_q.cle &&
        (pins_q.io_out == `NH_OPC_PROG || pins_q.io_out == `NH_OPC_ERASE ||
         pins_q.io_out == `NH_OPC_REPROG) |-> pins_q.wp_n)
        else $error("modify command with write protect low");
    a_reprog_addrs: assert property (
        $rose(pins_q.we_n) && pins_q.cle && op_q == OP_REPROG &&
        state_q == S_CMD2 |-> aseen_q == 3'h5)
        else $error("re-program confirm without five addresses");
    a_erase_addrs: assert property (
        $rose(pins_q.we_n) && pins_q.cle && op_q == OP_ERASE &&
        state_q == S_CMD2 |-> aseen_q == 3'h2)
        else $error("erase confirm without two addresses");
    a_id_len: assert property (
        rd_valid_q && op_q == OP_ID |-> cnt_q <= `NH_ID_BYTES)
        else $error("identification read past fourth byte");
    a_uid_after_rdy: assert property (
        $fell(pins_q.read_strobe_n) && op_q == OP_UID
        |-> $past(rb_s_q, 1) || cnt_q != 16'h0)
        else $error("unique identifier read before ready");
    a_reset_done: assert property (
        abort_ok |=> state_q == S_CMD1 ##0 op_q == OP_RESET
        ##[1:40] $rose(pins_q.we_n))
        else $error("reset abort not issued");

    c_reset: cover property ($rose(pins_q.we_n) && pins_q.cle &&
        pins_q.io_out == `NH_OPC_RESET);
    c_id_done: cover property (done_q && op_q == OP_ID);
    c_uid_done: cover property (done_q && op_q == OP_UID);
    c_abort: cover property (abort_ok);

endmodule // nand_host

// [nand_dev_model.sv]
// Behavioural NAND device standing on the far side of the host sequencer
`timescale 1ns/1ps
module nand_dev_model #(
    parameter logic [31:0] ID_CODE = 32'h1a2b3c4d, // Arbitrary value
    parameter int T_OP_NS = 2000,
    parameter int T_RD_NS = 800,
    parameter int T_RST_NS = 500
) (
    input wire nand_host_pkg::pins_t pins,
    input wire logic [7:0] io_wire,
    input wire logic bad_uid,
    output logic rb_n,
    output logic [7:0] dev_io,
    output logic [31:0] cmds,
    output logic [7:0] n_addr,
    output logic [7:0] n_data,
    output logic [7:0] last_data,
    output logic [7:0] status
);
    import nand_host_pkg::*;
    localparam logic [31:0] ONFI_SIG = 32'h4f4e4649;
    int busy_ns = 0;
    int idx = 0;
    logic in_rst = 1'b0;
    logic [1:0] mode = 2'd0;
    logic [7:0] sel = 8'h00;
    assign rb_n = (busy_ns == 0);
    initial begin
        {dev_io, cmds, n_addr, n_data, last_data, status} = '0;
    end
    always #10 begin
        if (busy_ns > 0) busy_ns -= 10;
        else in_rst = 1'b0;
    end
    function automatic logic [7:0] rd_byte(input int i);
        logic [7:0] u;
        u = 8'h30 + 8'(i % 16);
        if (mode == 2'd1 && i < 4) begin
            return sel == 8'h20 ? ONFI_SIG[31-8*i -: 8] :
                ID_CODE[31-8*i -: 8];
        end
        if (mode == 2'd2 && i % 32 >= 16) begin
            return ~u ^ {7'h0, bad_uid && i == 20};
        end
        return mode == 2'd2 ? u : 8'(i) ^ 8'h5a;
    endfunction
    task automatic take_cmd(input logic [7:0] c);
        if (c == 8'hff) begin
            if (!(in_rst && !rb_n)) begin
                cmds = {cmds[23:0], c};
                mode = 2'd0;
                status = pins.wp_n ? 8'he0 : 8'h60;
                busy_ns = T_RST_NS;
                in_rst = 1'b1;
            end
        end else if (rb_n) begin
            cmds = {cmds[23:0], c};
            mode = c == 8'h90 ? 2'd1 : c == 8'hed ? 2'd2 : 2'd0;
            if (!(c inside {8'h10, 8'h15, 8'h35, 8'hd0})) begin
                n_addr = 8'h00;
                n_data = 8'h00;
            end else if (c == 8'h35 || pins.wp_n) begin
                busy_ns = T_OP_NS;
            end
        end
    endtask
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.read_strobe_n) begin
            if (pins.cle && !pins.ale) begin
                take_cmd(io_wire);
            end else if (pins.ale && !pins.cle) begin
                n_addr++;
                sel = io_wire;
                idx = 0;
                if (mode == 2'd2) busy_ns = T_RD_NS;
            end else if (!pins.ale && !pins.cle && rb_n) begin
                n_data++;
                last_data = io_wire;
            end
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (!pins.ce_n) begin
            dev_io = rd_byte(idx);
            idx++;
        end
    end
    // Released bus keeps the stale byte for 15 ns, then shows its inverse
    always @(posedge pins.read_strobe_n) begin
        #15;
        dev_io = ~dev_io;
    end
endmodule // nand_dev_model

// [tb_top.sv]
// Self-checking testbench for the NAND host sequencer
`timescale 1ns/1ps
module tb_top;
    import nand_host_pkg::*;
    localparam logic [31:0] ID_CODE = 32'h1a2b3c4d; // Arbitrary value
    localparam logic [31:0] ONFI_SIG = 32'h4f4e4649;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_start = 1'b0;
    req_t req = '0;
    logic wp_enable = 1'b0;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic bad_uid = 1'b0;
    pins_t pins;
    logic wr_ready_q, rd_valid_q, busy_q, done_q, refused_q, aborted_q;
    logic uid_bad_q, dev_rb_n;
    logic [7:0] rd_data_q, dev_io, io_in, n_addr, n_data, last_data, status;
    logic [31:0] cmds;
    int err_count = 0;
    int num_checks = 0;
    logic [7:0] rd_q[$];
    logic [7:0] wq[$];
    assign io_in = pins.io_oe ? pins.io_out : dev_io;
    nand_host u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .req_start(req_start), .req(req), .wp_enable(wp_enable),
        .wr_valid(wr_valid), .wr_data(wr_data), .rb_n(dev_rb_n),
        .io_in(io_in), .pins_q(pins), .wr_ready_q(wr_ready_q),
        .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .busy_q(busy_q),
        .done_q(done_q), .refused_q(refused_q), .aborted_q(aborted_q),
        .uid_bad_q(uid_bad_q));
    nand_dev_model #(.ID_CODE(ID_CODE)) u_dev (.pins(pins),
        .io_wire(io_in), .bad_uid(bad_uid), .rb_n(dev_rb_n),
        .dev_io(dev_io), .cmds(cmds), .n_addr(n_addr), .n_data(n_data),
        .last_data(last_data), .status(status));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic start(input op_t op, input logic cache,
        input logic [39:0] a, input logic [15:0] len);
        @(posedge core_clk);
        #1;
        req = '{op: op, cache: cache, addr: a, len: len};
        req_start = 1'b1;
        @(posedge core_clk);
        #1;
        req_start = 1'b0;
    endtask
    task automatic wait_done();
        logic tk;
        rd_q = {};
        for (int i = 0; i < 20000; i++) begin
            tk = wr_valid && wr_ready_q;
            @(posedge core_clk);
            #1;
            if (tk) void'(wq.pop_front());
            wr_valid = wq.size() > 0;
            wr_data = wq.size() > 0 ? wq[0] : 8'h00;
            if (rd_valid_q === 1'b1) rd_q.push_back(rd_data_q);
            if (done_q === 1'b1) return;
        end
        check("done", 1, 0);
        print_verdict();
    endtask
    task automatic t_id();
        for (int k = 0; k < 2; k++) begin
            start(OP_ID, 1'b0, k ? 40'h20 : 40'h00, 16'h0);
            check("id taken", 0, refused_q);
            check("busy", 1, busy_q);
            start(OP_ID, 1'b0, 40'h00, 16'h0);
            check("busy refuse", 1, refused_q);
            wait_done();
            check("id count", 4, rd_q.size());
            for (int i = 0; i < 4; i++) begin
                check("id byte", k ? ONFI_SIG[31-8*i -: 8] :
                    ID_CODE[31-8*i -: 8], rd_q[i]);
            end
            check("id cmd", 8'h90, cmds[7:0]);
            check("id addr", 1, n_addr);
        end
        $display("Test id done");
    endtask
    task automatic t_uid();
        for (int k = 0; k < 2; k++) begin
            bad_uid = k[0];
            start(OP_UID, 1'b0, 40'h0, 16'h0);
            wait_done();
            check("uid count", 32, rd_q.size());
            for (int i = 0; i < 16; i++) begin
                check("uid value", 8'h30 + i, rd_q[i]);
                check("uid pair", (k && i == 4) ? 8'hfe : 8'hff,
                    rd_q[i] ^ rd_q[i+16]);
            end
            check("uid bad", k, uid_bad_q);
        end
        bad_uid = 1'b0;
        $display("Test uid done");
    endtask
    task automatic t_ops();
        op_t ops[6] = '{OP_MOVE_RD, OP_MOVE_WR, OP_REPROG, OP_ERASE,
            OP_PROG, OP_PROG};
        logic [15:0] seq[6] = '{16'h0035, 16'h8510, 16'h8b10, 16'h60d0,
            16'h8010, 16'h8015};
        logic [7:0] na[6] = '{8'h04, 8'h04, 8'h05, 8'h02, 8'h04, 8'h04};
        logic [15:0] ln;
        for (int k = 0; k < 6; k++) begin
            ln = (k == 0 || k == 3) ? 16'h0 : 16'h2;
            wq = {};
            if (ln != 0) wq = '{8'ha5, 8'h3c};
            wr_valid = ln != 0;
            wr_data = 8'ha5;
            start(ops[k], k == 5, 40'h0504030201, ln);
            wait_done();
            check("op cmds", seq[k], cmds[15:0]);
            check("op addr", na[k], n_addr);
            check("op data", ln[7:0], n_data);
            if (ln != 0) check("op last", 8'h3c, last_data);
        end
        $display("Test ops done");
    endtask
    task automatic t_abort();
        start(OP_PROG, 1'b0, 40'h0, 16'h0);
        for (int i = 0; i < 400 && dev_rb_n; i++) @(posedge core_clk);
        check("dev busy", 0, dev_rb_n);
        // Let the host pass its busy-edge wait before aborting
        repeat (20) @(posedge core_clk);
        start(OP_RESET, 1'b0, 40'h0, 16'h0);
        check("abort taken", 0, refused_q);
        wait_done();
        check("aborted", 1, aborted_q);
        check("reset cmd", 8'hff, cmds[7:0]);
        check("ready", 1, dev_rb_n);
        check("status wp high", 8'he0, status);
        wp_enable = 1'b0;
        start(OP_PROG, 1'b0, 40'h0, 16'h0);
        check("wp refuse", 1, refused_q);
        check("ce idle", 1, pins.ce_n);
        start(OP_RESET, 1'b0, 40'h0, 16'h0);
        wait_done();
        check("aborted clear", 0, aborted_q);
        check("status wp low", 8'h60, status);
        wp_enable = 1'b1;
        $display("Test abort done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check("ce reset", 1, pins.ce_n);
        wp_enable = 1'b1;
        t_id();
        t_uid();
        t_ops();
        t_abort();
        t_id();
        print_verdict();
    end
endmodule // tb_top
